// ### design/dspd_pkg.sv
/*
  dspd_pkg: constants for the dual stepper pulse driver.
  Assumes a 125 MHz bus clock and word-aligned AHB-Lite register access.
*/
package dspd_pkg;

  localparam int NUM_CH = 2;
  localparam int WIDTH_W = 5;
  localparam int DIV_W = 18;
  localparam int PER_W = 5;

  // clock rate and base-clock frequencies
  localparam longint CLK_HZ = 125_000_000;
  localparam longint BASE_LONG_HZ = 512;
  localparam longint BASE_SHORT_HZ = 4096;
  // one base period in bus cycles, rounded down
  localparam int LONG_DIV = int'(CLK_HZ / BASE_LONG_HZ);
  localparam int SHORT_DIV = int'(CLK_HZ / BASE_SHORT_HZ);

  // pulse length is (PER_BASE + code) base periods
  localparam logic [PER_W-1:0] PER_BASE = 5'h06;
  localparam logic [WIDTH_W-1:0] WIDTH_FOLD = 5'h08;
  localparam logic [1:0] WIDTH_TOP_BAD = 2'h3;

  // register indices; byte address is four times the index
  localparam logic [29:0] IDX_TRIG = 30'h0000FF10;
  localparam logic [29:0] IDX_CH1_HI = 30'h0000FF11;
  localparam logic [29:0] IDX_CH1_LO = 30'h0000FF12;
  localparam logic [29:0] IDX_CH2_HI = 30'h0000FF13;
  localparam logic [29:0] IDX_CH2_LO = 30'h0000FF14;
  localparam logic [29:0] IDX_BASE = 30'h0000FF15;
  localparam logic [29:0] IDX_MASK = 30'h0000FFE8;
  localparam logic [29:0] IDX_FLAGS = 30'h0000FFF8;
  localparam logic [29:0] IDX_CLEAR = 30'h0000FFF9;

  // decoded register selector
  typedef enum logic [3:0] {
    DSPD_R_NONE,
    DSPD_R_TRIG,
    DSPD_R_CH1_HI,
    DSPD_R_CH1_LO,
    DSPD_R_CH2_HI,
    DSPD_R_CH2_LO,
    DSPD_R_BASE,
    DSPD_R_MASK,
    DSPD_R_FLAGS,
    DSPD_R_CLEAR
  } dspd_reg_t;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [WIDTH_W-1:0] WIDTH_RST = 5'h00;
  localparam logic [31:0] RDATA_ZERO = 32'h00000000;

endpackage

// ### design/dspd_top.sv
/*
  dspd_top: two-channel stepping motor pulse driver with AHB-Lite registers.
  Assumes single-word AHB-Lite transfers, one clock (hclk), and that
  hclk_en stays high while a bus transfer is in progress.
*/
// Behaviour
// - two independent pulse channels
// - shared select: 512 Hz or 4 kHz base
// - pulse lasts six plus code base periods
// - codes with top bits 11 act as 8
// - writing 1 to bit0 starts channel one
// - first pulse on output a, then alternate
// - channel two same, on bit1
// - trigger bit reads back run status
// - pulse starts promptly after trigger write
// - trigger while running is ignored
// - completion sets flag; mask gates interrupt
// - writing 1 clears a done flag
// - mask bit per channel, 1 enables
// - width code split high bit, low nibble
// - reset clears widths, select, status, masks, flags
// - unused bits read zero, writes dropped
`timescale 1ns/10ps
`default_nettype none
module dspd_top #(
  parameter int LONG_DIV = dspd_pkg::LONG_DIV,
  parameter int SHORT_DIV = dspd_pkg::SHORT_DIV
) (
  // clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hclk_en,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // motor drive
  output logic ch1_drive_out_a,
  output logic ch1_drive_out_b,
  output logic ch2_drive_out_a,
  output logic ch2_drive_out_b,
  // interrupt
  output logic irq
);

  typedef struct packed {
    logic [dspd_pkg::NUM_CH-1:0][dspd_pkg::WIDTH_W-1:0] width;
    logic base_sel;
    logic [dspd_pkg::NUM_CH-1:0] run;
    logic [dspd_pkg::NUM_CH-1:0] phase;
    logic [dspd_pkg::NUM_CH-1:0][dspd_pkg::DIV_W-1:0] div_cnt;
    logic [dspd_pkg::NUM_CH-1:0][dspd_pkg::PER_W-1:0] per_cnt;
    logic [dspd_pkg::NUM_CH-1:0] flag;
    logic [dspd_pkg::NUM_CH-1:0] mask;
    logic [dspd_pkg::NUM_CH-1:0] out_a;
    logic [dspd_pkg::NUM_CH-1:0] out_b;
    logic irq;
    logic dp_wr;
    dspd_pkg::dspd_reg_t dp_reg;
    logic [31:0] rdata;
    logic ready;
  } dspd_state_t;

  dspd_state_t st_r;
  dspd_state_t st_nxt;

  localparam logic [dspd_pkg::DIV_W-1:0] LONG_LAST = dspd_pkg::DIV_W'(LONG_DIV - 1);
  localparam logic [dspd_pkg::DIV_W-1:0] SHORT_LAST = dspd_pkg::DIV_W'(SHORT_DIV - 1);

  // field positions inside the five-bit width code and its registers
  localparam int CODE_HI = dspd_pkg::WIDTH_W - 1;
  localparam int CODE_TOP = dspd_pkg::WIDTH_W - 2;
  localparam int LO_HI = dspd_pkg::WIDTH_W - 2;
  localparam int FIELD_LSB = 0;
  localparam int CH1 = 0;
  localparam int CH2 = 1;
  // one count step for each counter
  localparam logic [dspd_pkg::PER_W-1:0] PER_STEP = 5'h01;
  localparam logic [dspd_pkg::DIV_W-1:0] DIV_STEP = 18'h00001;

  function automatic dspd_pkg::dspd_reg_t dspd_decode(input logic [29:0] idx);
    dspd_pkg::dspd_reg_t r;
    r = dspd_pkg::DSPD_R_NONE;
    if (idx == dspd_pkg::IDX_TRIG) begin
      r = dspd_pkg::DSPD_R_TRIG;
    end
    if (idx == dspd_pkg::IDX_CH1_HI) begin
      r = dspd_pkg::DSPD_R_CH1_HI;
    end
    if (idx == dspd_pkg::IDX_CH1_LO) begin
      r = dspd_pkg::DSPD_R_CH1_LO;
    end
    if (idx == dspd_pkg::IDX_CH2_HI) begin
      r = dspd_pkg::DSPD_R_CH2_HI;
    end
    if (idx == dspd_pkg::IDX_CH2_LO) begin
      r = dspd_pkg::DSPD_R_CH2_LO;
    end
    if (idx == dspd_pkg::IDX_BASE) begin
      r = dspd_pkg::DSPD_R_BASE;
    end
    if (idx == dspd_pkg::IDX_MASK) begin
      r = dspd_pkg::DSPD_R_MASK;
    end
    if (idx == dspd_pkg::IDX_FLAGS) begin
      r = dspd_pkg::DSPD_R_FLAGS;
    end
    // write-only alias of the flag clear
    if (idx == dspd_pkg::IDX_CLEAR) begin
      r = dspd_pkg::DSPD_R_CLEAR;
    end
    return r;
  endfunction

  // last period index for a width code
  function automatic logic [dspd_pkg::PER_W-1:0] dspd_last(
      input logic [dspd_pkg::WIDTH_W-1:0] code);
    logic [dspd_pkg::WIDTH_W-1:0] eff;
    eff = code;
    if (code[CODE_HI:CODE_TOP] == dspd_pkg::WIDTH_TOP_BAD) begin
      eff = dspd_pkg::WIDTH_FOLD;
    end
    // 6 + 23 - 1 fits five bits
    return dspd_pkg::PER_W'(dspd_pkg::PER_BASE + eff - PER_STEP);
  endfunction

  // read word for a decoded register; unused bits stay zero
  function automatic logic [31:0] dspd_rd_word(
      input dspd_state_t s,
      input dspd_pkg::dspd_reg_t r);
    logic [31:0] w;
    w = dspd_pkg::RDATA_ZERO;
    unique case (r)
      dspd_pkg::DSPD_R_TRIG: begin
        w[dspd_pkg::NUM_CH-1:FIELD_LSB] = s.run;
      end
      dspd_pkg::DSPD_R_CH1_HI: begin
        w[FIELD_LSB] = s.width[CH1][CODE_HI];
      end
      dspd_pkg::DSPD_R_CH1_LO: begin
        w[LO_HI:FIELD_LSB] = s.width[CH1][LO_HI:FIELD_LSB];
      end
      dspd_pkg::DSPD_R_CH2_HI: begin
        w[FIELD_LSB] = s.width[CH2][CODE_HI];
      end
      dspd_pkg::DSPD_R_CH2_LO: begin
        w[LO_HI:FIELD_LSB] = s.width[CH2][LO_HI:FIELD_LSB];
      end
      dspd_pkg::DSPD_R_BASE: begin
        w[FIELD_LSB] = s.base_sel;
      end
      dspd_pkg::DSPD_R_MASK: begin
        w[dspd_pkg::NUM_CH-1:FIELD_LSB] = s.mask;
      end
      dspd_pkg::DSPD_R_FLAGS: begin
        w[dspd_pkg::NUM_CH-1:FIELD_LSB] = s.flag;
      end
      // clear register is write-only; holes read zero
      dspd_pkg::DSPD_R_CLEAR, dspd_pkg::DSPD_R_NONE: begin
      end
    endcase
    return w;
  endfunction

  always_comb begin
    logic addr_ok;
    logic [dspd_pkg::NUM_CH-1:0] trig;
    logic [dspd_pkg::NUM_CH-1:0] clr;
    logic [dspd_pkg::NUM_CH-1:0] done;
    logic [dspd_pkg::DIV_W-1:0] div_last;
    dspd_pkg::dspd_reg_t rsel;
    addr_ok = 1'b0;
    trig = '0;
    clr = '0;
    done = '0;
    div_last = '0;
    rsel = dspd_pkg::DSPD_R_NONE;
    st_nxt = st_r;

    // data phase of a write: apply hwdata
    if (st_r.dp_wr) begin
      unique case (st_r.dp_reg)
        dspd_pkg::DSPD_R_TRIG: begin
          trig = hwdata[dspd_pkg::NUM_CH-1:FIELD_LSB];
        end
        dspd_pkg::DSPD_R_CH1_HI: begin
          st_nxt.width[CH1][CODE_HI] = hwdata[FIELD_LSB];
        end
        dspd_pkg::DSPD_R_CH1_LO: begin
          st_nxt.width[CH1][LO_HI:FIELD_LSB] = hwdata[LO_HI:FIELD_LSB];
        end
        dspd_pkg::DSPD_R_CH2_HI: begin
          st_nxt.width[CH2][CODE_HI] = hwdata[FIELD_LSB];
        end
        dspd_pkg::DSPD_R_CH2_LO: begin
          st_nxt.width[CH2][LO_HI:FIELD_LSB] = hwdata[LO_HI:FIELD_LSB];
        end
        dspd_pkg::DSPD_R_BASE: begin
          st_nxt.base_sel = hwdata[FIELD_LSB];
        end
        dspd_pkg::DSPD_R_MASK: begin
          st_nxt.mask = hwdata[dspd_pkg::NUM_CH-1:FIELD_LSB];
        end
        // both addresses clear: flags take write-one-to-clear directly
        dspd_pkg::DSPD_R_FLAGS, dspd_pkg::DSPD_R_CLEAR: begin
          clr = hwdata[dspd_pkg::NUM_CH-1:FIELD_LSB];
        end
        // unmapped: write dropped
        dspd_pkg::DSPD_R_NONE: begin
        end
      endcase
    end

    // timing changes mid-pulse take effect at once; software keeps idle
    div_last = st_r.base_sel ? SHORT_LAST : LONG_LAST;

    for (int c = 0; c < dspd_pkg::NUM_CH; c++) begin
      if (st_r.run[c]) begin
        if (st_r.div_cnt[c] >= div_last) begin
          st_nxt.div_cnt[c] = '0;
          if (st_r.per_cnt[c] >= dspd_last(st_r.width[c])) begin
            done[c] = 1'b1;
            st_nxt.run[c] = 1'b0;
            st_nxt.phase[c] = ~st_r.phase[c];
          end else begin
            st_nxt.per_cnt[c] = st_r.per_cnt[c] + PER_STEP;
          end
        end else begin
          st_nxt.div_cnt[c] = st_r.div_cnt[c] + DIV_STEP;
        end
      end else if (trig[c]) begin
        // start at once, own divider restarted so width is exact
        st_nxt.run[c] = 1'b1;
        st_nxt.div_cnt[c] = '0;
        st_nxt.per_cnt[c] = '0;
      end
      // a trigger while running falls through untouched
      // set wins over clear in the same cycle
      st_nxt.flag[c] = (st_r.flag[c] & ~clr[c]) | done[c];
      st_nxt.out_a[c] = st_nxt.run[c] & ~st_nxt.phase[c];
      st_nxt.out_b[c] = st_nxt.run[c] & st_nxt.phase[c];
    end

    st_nxt.irq = |(st_nxt.flag & st_nxt.mask);

    // address phase: decode and prepare read data
    st_nxt.dp_wr = 1'b0;
    st_nxt.dp_reg = dspd_pkg::DSPD_R_NONE;
    st_nxt.ready = 1'b1;
    if (hsel && hready && htrans == dspd_pkg::HTRANS_NONSEQ) begin
      addr_ok = 1'b1;
      rsel = dspd_decode(haddr[31:2]);
    end
    st_nxt.rdata = dspd_pkg::RDATA_ZERO;
    if (addr_ok) begin
      st_nxt.dp_wr = hwrite;
      st_nxt.dp_reg = rsel;
      // read data registered here so hrdata stands in the data phase
      if (!hwrite) begin
        st_nxt.rdata = dspd_rd_word(st_r, rsel);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
      st_r.width <= {dspd_pkg::WIDTH_RST, dspd_pkg::WIDTH_RST};
      st_r.ready <= 1'b1;
    end else if (hclk_en) begin
      st_r <= st_nxt;
    end
  end

  assign hrdata = st_r.rdata;
  assign hreadyout = st_r.ready;
  assign hresp = 1'b0;

  // per-channel drive nets, each bit straight from its register
  logic [dspd_pkg::NUM_CH-1:0] drive_a;
  logic [dspd_pkg::NUM_CH-1:0] drive_b;
  for (genvar g = 0; g < dspd_pkg::NUM_CH; g++) begin : g_ch
    assign drive_a[g] = st_r.out_a[g];
    assign drive_b[g] = st_r.out_b[g];
  end

  assign ch1_drive_out_a = drive_a[CH1];
  assign ch1_drive_out_b = drive_b[CH1];
  assign ch2_drive_out_a = drive_a[CH2];
  assign ch2_drive_out_b = drive_b[CH2];
  assign irq = st_r.irq;

endmodule
`default_nettype wire

// ### test/dspd_assertions.sv
/*
  dspd_checker: port-level assertions for dspd_top, attached by bind.
  Assumes zero-wait AHB-Lite slave and small divider parameters (pulses of at most 200 cycles).
*/
`timescale 1ns/10ps
`default_nettype none
module dspd_checker (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  // motor drive
  input wire logic ch1_drive_out_a,
  input wire logic ch1_drive_out_b,
  input wire logic ch2_drive_out_a,
  input wire logic ch2_drive_out_b
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic tw_r;
  logic run1;
  logic run2;
  assign run1 = ch1_drive_out_a || ch1_drive_out_b;
  assign run2 = ch2_drive_out_a || ch2_drive_out_b;
  // high during the data phase of a trigger register write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tw_r <= 1'b0;
    else tw_r <= hsel && hready && htrans == dspd_pkg::HTRANS_NONSEQ && hwrite
      && haddr == {dspd_pkg::IDX_TRIG, 2'h0};
  end
  pair_excl1_a: assert property (!(ch1_drive_out_a && ch1_drive_out_b)) else $error("ch1 both on");
  pair_excl2_a: assert property (!(ch2_drive_out_a && ch2_drive_out_b)) else $error("ch2 both on");
  start_ch1_a: assert property (tw_r && hwdata[0] && !run1 |=> run1) else $error("ch1 no start");
  zero_noop_a: assert property (tw_r && !hwdata[0] && !run1 |=> !run1) else $error("ch1 zero start");
  start_ch2_a: assert property (tw_r && hwdata[1] && !run2 |=> run2) else $error("ch2 no start");
  retrig_keep_a: assert property (tw_r && hwdata[0] && ch1_drive_out_a |=> !ch1_drive_out_b)
    else $error("ch1 retrigger switched");
  min_width_a: assert property ($rose(ch1_drive_out_a) |-> ch1_drive_out_a[*8])
    else $error("ch1 pulse too short");
  max_width_a: assert property ($rose(run2) |-> ##[1:200] !run2) else $error("ch2 pulse too long");
endmodule
bind dspd_top dspd_checker chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .ch1_drive_out_a(ch1_drive_out_a), .ch1_drive_out_b(ch1_drive_out_b),
  .ch2_drive_out_a(ch2_drive_out_a), .ch2_drive_out_b(ch2_drive_out_b));
`default_nettype wire

// ### test/dspd_motor_model.sv
/*
  dspd_motor_model: one stepping motor coil pair; records side and length of the last pulse.
  Assumes active-high drive sampled on hclk.
*/
`timescale 1ns/10ps
`default_nettype none
module dspd_motor_model (
  // coil pair
  input wire logic hclk,
  input wire logic coil_a,
  input wire logic coil_b,
  // last pulse seen
  output var logic side_r,
  output var int len_r
);
  int cnt = 0;
  initial begin
    side_r = 1'b0;
    len_r = 0;
  end
  // a pulse cut by reset is still recorded, with its short length
  always @(posedge hclk) begin
    if (coil_a || coil_b) begin
      cnt <= cnt + 1;
      side_r <= coil_b;
    end else if (cnt != 0) begin
      len_r <= cnt;
      cnt <= 0;
    end
  end
endmodule
`default_nettype wire

// ### test/tb.sv
/*
  tb: self-checking bench for dspd_top over AHB-Lite with two motor models.
  Assumes dividers shrunk to 4 (long) and 2 (short) bus cycles per base period.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = '0, side_n = '0, msk = '0;
  logic hreadyout, hresp, irq, a1, b1, a2, b2, s1, s2;
  int num_errors = 0, n_compared = 0, len1, len2;
  localparam logic [29:0] RI[9] = '{dspd_pkg::IDX_CH1_HI, dspd_pkg::IDX_CH1_LO,
    dspd_pkg::IDX_CH2_HI, dspd_pkg::IDX_CH2_LO, dspd_pkg::IDX_BASE, dspd_pkg::IDX_MASK,
    dspd_pkg::IDX_FLAGS, 30'h0000FF16, dspd_pkg::IDX_CLEAR};
  localparam logic [31:0] RE[9] = '{32'h1, 32'hF, 32'h1, 32'hF, 32'h1, 32'h3, 32'h0, 32'h0,
    32'h0};
  always #4 hclk = ~hclk;
  dspd_top #(.LONG_DIV(4), .SHORT_DIV(2)) dut_u (.hclk(hclk), .hresetn(hresetn), .hclk_en(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ch1_drive_out_a(a1), .ch1_drive_out_b(b1), .ch2_drive_out_a(a2), .ch2_drive_out_b(b2),
    .irq(irq));
  dspd_motor_model m1_u (.hclk(hclk), .coil_a(a1), .coil_b(b1), .side_r(s1), .len_r(len1));
  dspd_motor_model m2_u (.hclk(hclk), .coil_a(a2), .coil_b(b2), .side_r(s2), .len_r(len2));
  task report_and_stop;
    if (num_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task xfer(input logic [29:0] idx, input logic w, input logic [31:0] wd);
    @(posedge hclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, dspd_pkg::HTRANS_NONSEQ, w, idx, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task rdc(input string nm, input logic [29:0] idx, input logic [31:0] e);
    xfer(idx, 1'b0, 32'h0);
    chk(nm, e, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task run_pulse(input int ch, input logic [4:0] code, input logic base);
    int n;
    n = code[4:3] == 2'h3 ? 8 : int'(code);
    xfer(ch == 1 ? dspd_pkg::IDX_CH1_HI : dspd_pkg::IDX_CH2_HI, 1'b1, {31'h0, code[4]});
    xfer(ch == 1 ? dspd_pkg::IDX_CH1_LO : dspd_pkg::IDX_CH2_LO, 1'b1, {28'h0, code[3:0]});
    xfer(dspd_pkg::IDX_BASE, 1'b1, {31'h0, base});
    xfer(dspd_pkg::IDX_TRIG, 1'b1, 32'(ch));
    rdc("run", dspd_pkg::IDX_TRIG, 32'(ch));
    xfer(dspd_pkg::IDX_TRIG, 1'b1, 32'(ch));
    repeat (200) begin
      xfer(dspd_pkg::IDX_TRIG, 1'b0, 32'h0);
      if (rd[ch-1] === 1'b0) break;
    end
    chk("idle", 32'h0, rd);
    chk("len", 32'((6 + n) * (base ? 2 : 4)), 32'(ch == 1 ? len1 : len2));
    chk("side", {31'h0, side_n[ch-1]}, {31'h0, ch == 1 ? s1 : s2});
    side_n[ch-1] = ~side_n[ch-1];
    rdc("flag", dspd_pkg::IDX_FLAGS, 32'(ch));
    chk("irq", {31'h0, msk[ch-1]}, {31'h0, irq});
    xfer(ch == 1 ? dspd_pkg::IDX_FLAGS : dspd_pkg::IDX_CLEAR, 1'b1, 32'(ch));
    rdc("clear", dspd_pkg::IDX_FLAGS, 32'h0);
  endtask
  initial begin
    repeat (50000) @(posedge hclk);
    num_errors++;
    report_and_stop;
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (RI[i]) begin
      xfer(RI[i], 1'b1, 32'hFFFFFFFF);
      rdc("reg", RI[i], RE[i]);
    end
    xfer(dspd_pkg::IDX_TRIG, 1'b1, 32'h0);
    rdc("trig0", dspd_pkg::IDX_TRIG, 32'h0);
    xfer(dspd_pkg::IDX_MASK, 1'b1, 32'h1);
    msk = 2'h1;
    run_pulse(1, 5'h00, 1'b0);
    run_pulse(1, 5'h17, 1'b1);
    run_pulse(1, 5'h18, 1'b0);
    xfer(dspd_pkg::IDX_MASK, 1'b1, 32'h2);
    msk = 2'h2;
    run_pulse(2, 5'h1F, 1'b1);
    run_pulse(2, 5'h03, 1'b0);
    // reset in mid-pulse must drop the drive and restart alternation
    xfer(dspd_pkg::IDX_TRIG, 1'b1, 32'h1);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("rst_out", 32'h0, {31'h0, b1});
    hresetn <= 1'b1;
    foreach (RI[i]) rdc("reset", RI[i], 32'h0);
    rdc("reset_trig", dspd_pkg::IDX_TRIG, 32'h0);
    {side_n, msk} = 4'h0;
    run_pulse(1, 5'h01, 1'b1);
    report_and_stop;
  end
endmodule
`default_nettype wire
